// >>> inc/msup_defines.svh
// offsets, field positions, reset values and timing counts of the start supervisor
`ifndef MSUP_DEFINES_SVH
`define MSUP_DEFINES_SVH
`define MSUP_CLK_HZ 10000000
`define MSUP_TICK_MS 10
`define MSUP_TICK_CYC ((`MSUP_CLK_HZ / 1000) * `MSUP_TICK_MS)
`define MSUP_WIN_MS 5000
`define MSUP_WIN_TICKS (`MSUP_WIN_MS / `MSUP_TICK_MS)
`define MSUP_FREEZE_TICKS 16'h0BB8
`define MSUP_HOT_PCT 8'h32
`define MSUP_REG_CTRL 6'h00
`define MSUP_REG_LIMIT 6'h04
`define MSUP_REG_MON 6'h08
`define MSUP_REG_INH 6'h0C
`define MSUP_REG_SPC 6'h10
`define MSUP_REG_REACC 6'h14
`define MSUP_REG_STIM 6'h18
`define MSUP_REG_MED 6'h1C
`define MSUP_REG_LONG 6'h20
`define MSUP_REG_STAT 6'h24
`define MSUP_CTRL_DIP_INT 0
`define MSUP_CTRL_AR_EN 1
`define MSUP_RST_HOT 4'h2
`define MSUP_RST_COLD 4'h3
`define MSUP_RST_TMR 16'h0064
`define MSUP_RST_OFF 16'h0000
`endif

// >>> inc/msup_pkg.sv
// types shared by the start supervisor files
package msup_pkg;
   typedef logic [15:0] msup_tick_t;
   typedef struct packed {
      logic pos;
      logic start_det;
      logic [7:0] thermal;
      logic i_gt_stall;
      logic v_below_dip;
      logic v_above_rest;
      logic ext_dip;
   } msup_sense_s;
   typedef struct packed {
      logic dip_int;
      logic ar_en;
      logic [3:0] hot_lim;
      logic [3:0] cold_lim;
      msup_tick_t mon;
      msup_tick_t inh;
      msup_tick_t spc;
      msup_tick_t reacc;
      msup_tick_t stim;
      msup_tick_t med;
      msup_tick_t lng;
   } msup_cfg_s;
   typedef enum logic [1:0] {
      DIP_NORM = 2'b00,
      DIP_SAG = 2'b01,
      DIP_WATCH = 2'b10,
      DIP_LONG = 2'b11
   } msup_dip_e;
endpackage : msup_pkg

// >>> verilog/msup_tmr.sv
// tick driven supervision timer with expiry flag
`timescale 1ns/1ps
module msup_tmr #(
   parameter int TW = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic tick,
   input wire logic start,
   input wire logic clear,
   input wire logic [TW-1:0] setting,
   output logic running,
   output logic expire
);
   logic [TW-1:0] cnt_r;
   logic run_r;
   // expiry flagged in the cycle the count reaches the setting
   assign expire = run_r & ce & tick & (({1'b0, cnt_r} + (TW+1)'(1)) >= {1'b0, setting}); // R21
   assign running = run_r;
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         run_r <= 1'b0;
         cnt_r <= '0;
      end else if (ce) begin
         if (start) begin
            run_r <= 1'b1;
            cnt_r <= '0;
         end else if (clear || expire) begin
            run_r <= 1'b0;
         end else if (run_r && tick) begin
            cnt_r <= cnt_r + TW'(1); // R21
         end
      end
   end
endmodule : msup_tmr

// >>> verilog/msup_core.sv
// motor start limiter, start spacing, dip classifier and auto restart
//
// Contract
// R1 - start arms period timer, bumps counter
// R2 - thermal at most half means cold start
// R3 - stop at limit raises inhibit for time
// R4 - counter expired before stop gives no inhibit
// R5 - inhibit held while counter stays at limit
// R6 - long gap without limit freezes permit one
// R7 - each start restarts spacing timer
// R8 - stop during spacing raises spacing inhibit
// R9 - setting picks external or internal dip source
// R10 - undervoltage detects dip, overvoltage detects restore
// R11 - dip starts reacceleration timer
// R12 - quick restore with current starts start monitoring
// R13 - quick restore without current changes nothing
// R14 - dip outlasting timer raises dip signal
// R15 - short dip forces reacceleration on restore
// R16 - restart armed only when enabled after trip
// R17 - nonzero medium delay starts restart timer
// R18 - restore in window closes, else disarms
// R19 - zero medium, nonzero long uses long delay
// R20 - position input follows contactor auxiliary contact
// R21 - timers count shared tick against settings
`timescale 1ns/1ps
`include "msup_defines.svh"
module msup_core #(
   parameter int TICK_CYC = `MSUP_TICK_CYC,
   parameter int SLOTS = 8,
   parameter int TW = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire msup_pkg::msup_sense_s sense,
   output logic start_count_inhibit,
   output logic spacing_inhibit,
   output logic volt_dip,
   output logic stall_run_en,
   output logic start_mon,
   output logic force_reaccel,
   output logic close_order,
   output logic restart_event,
   output logic restart_armed
);
   import msup_pkg::*;

   localparam int PW = $clog2(TICK_CYC + 1);
   localparam int CW = 4;

   msup_cfg_s cfg_r;
   logic [PW-1:0] pre_r;
   logic tick_r;
   logic ack_r;
   logic req;
   logic [31:0] rd_mux;
   logic [31:0] rdata_r;
   logic pos_r;
   logic stop_ev;
   logic start_ev;
   logic hot;
   logic [SLOTS-1:0] slot_run;
   logic [SLOTS-1:0] slot_exp;
   logic [SLOTS-1:0] slot_hot_r;
   logic [SLOTS-1:0] alloc;
   logic [CW-1:0] hot_cnt;
   logic [CW-1:0] cold_cnt;
   logic at_hot;
   logic at_cold;
   logic at_lim;
   logic inh_run;
   logic inh_exp;
   logic inh_ext_r;
   logic spc_run;
   logic spc_exp;
   logic spc_inh_r;
   msup_tick_t since_r;
   logic freeze_r;
   logic [CW-1:0] rem_h;
   logic [CW-1:0] rem_c;
   logic [CW-1:0] permitted;
   msup_dip_e dip_r;
   logic dip_det;
   logic restored;
   logic reacc_run;
   logic reacc_exp;
   logic win_run;
   logic win_exp;
   logic st_run;
   logic st_exp;
   logic rs_run;
   logic rs_exp;
   logic rs_start;
   msup_tick_t rs_set;
   logic volt_dip_r;
   logic force_r;
   logic armed_r;
   logic close_r;
   logic evt_r;

   // time base shared by every supervision timer
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pre_r <= '0;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= (pre_r == PW'(TICK_CYC - 1)); // R21
         if (pre_r == PW'(TICK_CYC - 1)) begin
            pre_r <= '0;
         end else begin
            pre_r <= pre_r + PW'(1);
         end
      end
   end

   // avalon slave: one wait cycle, then the access completes
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata = rdata_r;

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         ack_r <= 1'b0;
      end else if (ce) begin
         ack_r <= req & ~ack_r;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `MSUP_REG_CTRL: rd_mux = {30'h0, cfg_r.ar_en, cfg_r.dip_int};
         `MSUP_REG_LIMIT: rd_mux = {24'h0, cfg_r.cold_lim, cfg_r.hot_lim};
         `MSUP_REG_MON: rd_mux = {16'h0, cfg_r.mon};
         `MSUP_REG_INH: rd_mux = {16'h0, cfg_r.inh};
         `MSUP_REG_SPC: rd_mux = {16'h0, cfg_r.spc};
         `MSUP_REG_REACC: rd_mux = {16'h0, cfg_r.reacc};
         `MSUP_REG_STIM: rd_mux = {16'h0, cfg_r.stim};
         `MSUP_REG_MED: rd_mux = {16'h0, cfg_r.med};
         `MSUP_REG_LONG: rd_mux = {16'h0, cfg_r.lng};
         `MSUP_REG_STAT: rd_mux = {16'h0, permitted, cold_cnt, hot_cnt,
            restart_armed, volt_dip, spacing_inhibit, start_count_inhibit};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rdata_r <= 32'h0000_0000;
      end else if (ce && avs_read && !ack_r) begin
         rdata_r <= rd_mux;
      end
   end

   // unmapped and status writes are dropped
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cfg_r.dip_int <= 1'b0;
         cfg_r.ar_en <= 1'b0;
         cfg_r.hot_lim <= `MSUP_RST_HOT;
         cfg_r.cold_lim <= `MSUP_RST_COLD;
         cfg_r.mon <= `MSUP_RST_TMR;
         cfg_r.inh <= `MSUP_RST_TMR;
         cfg_r.spc <= `MSUP_RST_TMR;
         cfg_r.reacc <= `MSUP_RST_TMR;
         cfg_r.stim <= `MSUP_RST_TMR;
         cfg_r.med <= `MSUP_RST_OFF;
         cfg_r.lng <= `MSUP_RST_OFF;
      end else if (ce && avs_write && ack_r) begin
         case (avs_address)
            `MSUP_REG_CTRL: begin
               cfg_r.dip_int <= avs_writedata[`MSUP_CTRL_DIP_INT]; // R9
               cfg_r.ar_en <= avs_writedata[`MSUP_CTRL_AR_EN];
            end
            `MSUP_REG_LIMIT: begin
               cfg_r.hot_lim <= avs_writedata[3:0];
               cfg_r.cold_lim <= avs_writedata[7:4];
            end
            `MSUP_REG_MON: cfg_r.mon <= avs_writedata[15:0];
            `MSUP_REG_INH: cfg_r.inh <= avs_writedata[15:0];
            `MSUP_REG_SPC: cfg_r.spc <= avs_writedata[15:0];
            `MSUP_REG_REACC: cfg_r.reacc <= avs_writedata[15:0];
            `MSUP_REG_STIM: cfg_r.stim <= avs_writedata[15:0];
            `MSUP_REG_MED: cfg_r.med <= avs_writedata[15:0];
            `MSUP_REG_LONG: cfg_r.lng <= avs_writedata[15:0];
            default: cfg_r.lng <= cfg_r.lng;
         endcase
      end
   end

   // motor stop is the 1 to 0 edge of the position input
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pos_r <= 1'b0;
      end else if (ce) begin
         pos_r <= sense.pos; // R20
      end
   end
   assign stop_ev = ce & pos_r & ~sense.pos;
   assign start_ev = ce & sense.start_det;
   assign hot = sense.thermal > `MSUP_HOT_PCT; // R2

   // one period timer per start; a start with no free slot is not counted
   always_comb begin
      logic found;
      found = 1'b0;
      alloc = '0;
      for (int i = 0; i < SLOTS; i++) begin
         if (!slot_run[i] && !found) begin
            alloc[i] = start_ev; // R1
            found = 1'b1;
         end
      end
   end

   for (genvar g = 0; g < SLOTS; g++) begin : g_slot
      msup_tmr #(.TW(TW)) u_mon (
         .core_clk(core_clk),
         .rst_b(rst_b),
         .ce(ce),
         .tick(tick_r),
         .start(alloc[g]),
         .clear(1'b0),
         .setting(cfg_r.mon),
         .running(slot_run[g]),
         .expire(slot_exp[g])
      );
      always_ff @(posedge core_clk) begin
         if (!rst_b) begin
            slot_hot_r[g] <= 1'b0;
         end else if (alloc[g]) begin
            slot_hot_r[g] <= hot; // R2
         end
      end
   end

   // counter drops when its slot's period ends
   always_comb begin
      hot_cnt = '0;
      cold_cnt = '0;
      for (int i = 0; i < SLOTS; i++) begin
         hot_cnt = hot_cnt + CW'(slot_run[i] & slot_hot_r[i]); // R1
         cold_cnt = cold_cnt + CW'(slot_run[i] & ~slot_hot_r[i]); // R1
      end
   end

   assign at_hot = hot_cnt >= cfg_r.hot_lim;
   assign at_cold = cold_cnt >= cfg_r.cold_lim;
   assign at_lim = at_hot | at_cold;

   msup_tmr #(.TW(TW)) u_inh (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .tick(tick_r),
      .start(stop_ev & at_lim), // R3 R4
      .clear(1'b0),
      .setting(cfg_r.inh),
      .running(inh_run),
      .expire(inh_exp)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         inh_ext_r <= 1'b0;
      end else if (ce) begin
         if (inh_exp && at_lim) begin
            inh_ext_r <= 1'b1; // R5
         end else if (!at_lim) begin
            inh_ext_r <= 1'b0;
         end
      end
   end
   assign start_count_inhibit = inh_run | inh_ext_r; // R3 R5

   msup_tmr #(.TW(TW)) u_spc (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .tick(tick_r),
      .start(start_ev), // R7
      .clear(1'b0),
      .setting(cfg_r.spc),
      .running(spc_run),
      .expire(spc_exp)
   );

   // the expiry clear wins over a set in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         spc_inh_r <= 1'b0;
      end else if (ce) begin
         if (stop_ev && spc_run && !spc_exp) begin
            spc_inh_r <= 1'b1; // R8
         end else if (spc_exp || !spc_run) begin
            spc_inh_r <= 1'b0;
         end
      end
   end
   assign spacing_inhibit = spc_inh_r;

   // gap between starts, saturating
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         since_r <= '0;
         freeze_r <= 1'b0;
      end else if (ce) begin
         if (start_ev) begin
            since_r <= '0;
            freeze_r <= (since_r > `MSUP_FREEZE_TICKS) && !at_lim; // R6
         end else begin
            if (tick_r && since_r != 16'hFFFF) begin
               since_r <= since_r + 16'h0001;
            end
            if (at_lim) begin
               freeze_r <= 1'b0;
            end
         end
      end
   end

   assign rem_h = at_hot ? '0 : cfg_r.hot_lim - hot_cnt;
   assign rem_c = at_cold ? '0 : cfg_r.cold_lim - cold_cnt;
   assign permitted = freeze_r ? CW'(1) : ((rem_h < rem_c) ? rem_h : rem_c); // R6

   // dip source and thresholds
   assign dip_det = cfg_r.dip_int ? sense.v_below_dip : sense.ext_dip; // R9 R10
   assign restored = cfg_r.dip_int ? sense.v_above_rest : ~sense.ext_dip; // R9 R10

   msup_tmr #(.TW(TW)) u_reacc (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .tick(tick_r),
      .start(dip_r == DIP_NORM && dip_det && sense.pos), // R11
      .clear(dip_r == DIP_SAG && restored),
      .setting(cfg_r.reacc),
      .running(reacc_run),
      .expire(reacc_exp)
   );

   msup_tmr #(.TW(TW)) u_win (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .tick(tick_r),
      .start(dip_r == DIP_SAG && restored),
      .clear(dip_r == DIP_WATCH && sense.i_gt_stall),
      .setting(TW'(`MSUP_WIN_TICKS)),
      .running(win_run),
      .expire(win_exp)
   );

   msup_tmr #(.TW(TW)) u_st (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .tick(tick_r),
      .start(dip_r == DIP_WATCH && sense.i_gt_stall), // R12
      .clear(1'b0),
      .setting(cfg_r.stim),
      .running(st_run),
      .expire(st_exp)
   );
   assign start_mon = st_run;
   assign stall_run_en = ~st_run; // R12

   // short restore, watch for current, or long dip
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         dip_r <= DIP_NORM;
         volt_dip_r <= 1'b0;
         force_r <= 1'b0;
      end else if (ce) begin
         force_r <= 1'b0;
         case (dip_r)
            DIP_NORM: begin
               if (dip_det && sense.pos) begin
                  dip_r <= DIP_SAG; // R11
               end
            end
            DIP_SAG: begin
               if (restored) begin
                  dip_r <= DIP_WATCH;
                  force_r <= 1'b1; // R15
               end else if (reacc_exp) begin
                  dip_r <= DIP_LONG;
                  volt_dip_r <= 1'b1; // R14
               end
            end
            DIP_WATCH: begin
               if (sense.i_gt_stall) begin
                  dip_r <= DIP_NORM; // R12
               end else if (win_exp) begin
                  dip_r <= DIP_NORM; // R13
               end
            end
            DIP_LONG: begin
               if (restored) begin
                  dip_r <= DIP_NORM;
                  volt_dip_r <= 1'b0;
               end
            end
            default: dip_r <= DIP_NORM;
         endcase
      end
   end
   assign volt_dip = volt_dip_r;
   assign force_reaccel = force_r;

   // restart only after a long dip trip
   assign rs_set = (cfg_r.med != 16'h0000) ? cfg_r.med : cfg_r.lng; // R17 R19
   assign rs_start = dip_r == DIP_SAG && !restored && reacc_exp && cfg_r.ar_en
      && (cfg_r.med != 16'h0000 || cfg_r.lng != 16'h0000); // R16 R17 R19

   msup_tmr #(.TW(TW)) u_rs (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ce(ce),
      .tick(tick_r),
      .start(rs_start),
      .clear(rs_run && restored),
      .setting(rs_set),
      .running(rs_run),
      .expire(rs_exp)
   );

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         armed_r <= 1'b0;
         close_r <= 1'b0;
         evt_r <= 1'b0;
      end else if (ce) begin
         close_r <= 1'b0;
         evt_r <= 1'b0;
         if (rs_start) begin
            armed_r <= 1'b1; // R16
         end else if (rs_run && restored) begin
            armed_r <= 1'b0;
            close_r <= 1'b1; // R18
            evt_r <= 1'b1; // R18
         end else if (rs_exp) begin
            armed_r <= 1'b0; // R18
         end
      end
   end
   assign close_order = close_r;
   assign restart_event = evt_r;
   assign restart_armed = armed_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence s_restore_in_window;
      ce && rs_run && restored;
   endsequence
   sequence s_close_pulse;
      close_order && restart_event ##1 !close_order;
   endsequence
   sequence s_long_dip;
      ce && dip_r == DIP_SAG && !restored && reacc_exp;
   endsequence

   a_inh_on_stop: assert property (stop_ev && at_lim |=> start_count_inhibit) // R3
      else $error("stop at limit gave no start count inhibit");
   a_no_inh_clear: assert property (stop_ev && !at_lim && !start_count_inhibit // R4
      |=> !start_count_inhibit)
      else $error("inhibit raised with counters below limit");
   a_inh_held: assert property (ce && start_count_inhibit && at_lim && !stop_ev // R5
      |=> start_count_inhibit)
      else $error("inhibit dropped while counter at limit");
   a_spacing_inh: assert property (stop_ev && spc_run && !spc_exp // R8
      |=> spacing_inhibit [*1] ##0 spc_run)
      else $error("stop during spacing gave no spacing inhibit");
   a_freeze_one: assert property (start_ev && since_r > `MSUP_FREEZE_TICKS && !at_lim // R6
      |=> permitted == CW'(1))
      else $error("permitted starts not frozen at one");
   a_dip_signal: assert property (s_long_dip |=> volt_dip && dip_r == DIP_LONG) // R14
      else $error("long dip gave no voltage dip signal");
   a_stall_off: assert property (ce && dip_r == DIP_WATCH && sense.i_gt_stall // R12
      |=> !stall_run_en && start_mon)
      else $error("stall detection enabled during start monitoring");
   a_close_order: assert property (s_restore_in_window |=> s_close_pulse) // R18
      else $error("restore in restart window gave no close order");
   a_arm_enable: assert property ($rose(restart_armed) |-> cfg_r.ar_en && volt_dip) // R16
      else $error("restart armed without enable and dip trip");
   a_hot_count: assert property (start_ev && hot && alloc != '0 && slot_exp == '0 // R1 R2
      |=> hot_cnt == $past(hot_cnt) + CW'(1))
      else $error("hot start not counted");
endmodule : msup_core

// >>> verification/msup_plant.sv
// contactor and voltage relay model facing the start supervisor
`timescale 1ns/1ps
module msup_plant (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic go,
   input wire logic stop,
   input wire logic sag_int,
   input wire logic sag_ext,
   input wire logic amps,
   input wire logic [7:0] heat,
   input wire logic volt_dip,
   input wire logic close_order,
   output msup_pkg::msup_sense_s sense
);
   import msup_pkg::*;
   logic pos_r;
   logic det_r;
   logic dip_q_r;
   // trip output opens only on the rising dip, so a close can follow
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pos_r <= 1'b0;
         det_r <= 1'b0;
         dip_q_r <= 1'b0;
      end else begin
         dip_q_r <= volt_dip;
         det_r <= 1'b0;
         if (stop || (volt_dip && !dip_q_r)) begin
            pos_r <= 1'b0;
         end else if ((go || close_order) && !pos_r) begin
            pos_r <= 1'b1;
            det_r <= 1'b1;
         end
      end
   end
   // separate lines so each dip source can sag alone
   always_comb begin
      sense.pos = pos_r;
      sense.start_det = det_r;
      sense.thermal = heat;
      sense.i_gt_stall = amps;
      sense.v_below_dip = sag_int;
      sense.v_above_rest = !sag_int;
      sense.ext_dip = sag_ext;
   end
endmodule : msup_plant

// >>> verification/msup_tb.sv
// self-checking bench for the start supervisor
`timescale 1ns/1ps
`include "msup_defines.svh"
module testbench;
   import msup_pkg::*;
   localparam int SCI = 0;
   localparam int SPI = 1;
   localparam int VD = 2;
   localparam int SM = 4;
   localparam int FR = 5;
   localparam int CO = 6;
   localparam int RA = 8;
   logic core_clk = 1'b0;
   logic rst_b;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   msup_sense_s sense;
   logic start_count_inhibit, spacing_inhibit, volt_dip, stall_run_en, start_mon;
   logic force_reaccel, close_order, restart_event, restart_armed;
   logic go, stop, sag_int, sag_ext, amps;
   logic ce;
   logic [7:0] heat;
   logic [8:0] obs;
   int n_fail = 0;
   int n_compared = 0;
   logic [5:0] ra_tab [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C,
      6'h20, 6'h3C};
   logic [31:0] rv_tab [10] = '{32'h0, 32'h32, 32'h64, 32'h64, 32'h64, 32'h64, 32'h64,
      32'h0, 32'h0, 32'h0};
   // ctrl[6:5] medium[4] long[3] restore[2] armed[1] close[0]
   logic [6:0] dtab [6] = '{7'b1110111, 7'b1101111, 7'b1110010, 7'b0110100, 7'b1100100,
      7'b1010111};
   assign obs = {restart_armed, restart_event, close_order, force_reaccel, start_mon,
      stall_run_en, volt_dip, spacing_inhibit, start_count_inhibit};
   always #50 core_clk = ~core_clk;
   // short tick keeps every timer but the 2000 cycle restore window and the 12000 cycle freeze gap in the hundreds of cycles
   msup_core #(.TICK_CYC(4), .SLOTS(8), .TW(16)) msup_core_inst (
      .core_clk(core_clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sense(sense),
      .start_count_inhibit(start_count_inhibit), .spacing_inhibit(spacing_inhibit),
      .volt_dip(volt_dip), .stall_run_en(stall_run_en), .start_mon(start_mon),
      .force_reaccel(force_reaccel), .close_order(close_order),
      .restart_event(restart_event), .restart_armed(restart_armed));
   msup_plant msup_plant_inst (
      .core_clk(core_clk), .rst_b(rst_b), .go(go), .stop(stop), .sag_int(sag_int),
      .sag_ext(sag_ext), .amps(amps), .heat(heat), .volt_dip(volt_dip),
      .close_order(close_order), .sense(sense));
   task automatic final_report();
      $display("counts: %0d compared, %0d mismatches", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic av(input logic w, input logic [5:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      int k;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      if (k >= 20) begin
         chk("waitrequest", 0, avs_waitrequest);
         final_report();
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      av(1'b1, a, d, x);
   endtask : wr
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic wt(input int b, input logic v, input int lim, output int n);
      n = 0;
      while (obs[b] !== v && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= lim) begin
         chk($sformatf("wait bit %0d", b), v, obs[b]);
         final_report();
      end
   endtask : wt
   task automatic hold(input int b, input logic v, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge core_clk);
         if (obs[b] !== v) bad++;
      end
      chk($sformatf("hold bit %0d", b), 0, bad);
   endtask : hold
   task automatic pls(input logic s);
      @(posedge core_clk);
      if (s) stop <= 1'b1;
      else go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      stop <= 1'b0;
   endtask : pls
   initial begin
      logic [31:0] d;
      logic [6:0] e;
      int n;
      {rst_b, avs_read, avs_write, go, stop, sag_int, sag_ext, amps} = '0;
      avs_address = '0;
      avs_writedata = '0;
      heat = '0;
      ce = 1'b1;
      cyc(5);
      rst_b <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         av(1'b0, ra_tab[i], 32'h0, d);
         chk("reset value", rv_tab[i], d);
      end
      wr(6'h3C, 32'hA5A5A5A5);
      av(1'b0, 6'h3C, 32'h0, d);
      chk("unmapped", 32'h0, d);
      $display("test registers done");
      wr(`MSUP_REG_LIMIT, 32'h21);
      wr(`MSUP_REG_MON, 32'h5);
      wr(`MSUP_REG_INH, 32'h5);
      wr(`MSUP_REG_SPC, 32'h0);
      heat <= 8'h33;
      pls(0);
      cyc(10);
      av(1'b0, `MSUP_REG_STAT, 32'h0, d);
      chk("hot count", 1, d[7:4]);
      cyc(30);
      pls(1);
      hold(SCI, 0, 30);
      av(1'b0, `MSUP_REG_STAT, 32'h0, d);
      chk("hot count", 0, d[7:4]);
      $display("test late stop done");
      wr(`MSUP_REG_MON, 32'h3C);
      heat <= 8'h32;
      pls(0);
      cyc(10);
      pls(1);
      hold(SCI, 0, 5);
      pls(0);
      cyc(10);
      av(1'b0, `MSUP_REG_STAT, 32'h0, d);
      chk("cold count", 2, d[11:8]);
      pls(1);
      wt(SCI, 1, 3, n);
      hold(SCI, 1, 40);
      wt(SCI, 0, 300, n);
      chk("inhibit held", 1, n > 100);
      $display("test start count done");
      wr(`MSUP_REG_SPC, 32'hA);
      pls(0);
      cyc(3);
      pls(1);
      wt(SPI, 1, 3, n);
      hold(SPI, 1, 20);
      // enable low must freeze the spacing timer past its normal expiry
      ce <= 1'b0;
      hold(SPI, 1, 60);
      ce <= 1'b1;
      wt(SPI, 0, 30, n);
      pls(0);
      cyc(50);
      pls(1);
      hold(SPI, 0, 10);
      $display("test spacing done");
      wr(`MSUP_REG_LIMIT, 32'h33);
      wr(`MSUP_REG_MON, 32'h64);
      pls(0);
      cyc(5);
      pls(1);
      cyc(12100);
      pls(0);
      cyc(5);
      av(1'b0, `MSUP_REG_STAT, 32'h0, d);
      chk("permitted", 1, d[15:12]);
      $display("test freeze done");
      wr(`MSUP_REG_CTRL, 32'h1);
      wr(`MSUP_REG_REACC, 32'hA);
      wr(`MSUP_REG_STIM, 32'h5);
      sag_int <= 1'b1;
      cyc(10);
      sag_int <= 1'b0;
      amps <= 1'b1;
      wt(FR, 1, 10, n);
      wt(SM, 1, 20, n);
      chk("stall run", 0, stall_run_en);
      wt(SM, 0, 40, n);
      chk("stall run", 1, stall_run_en);
      amps <= 1'b0;
      sag_int <= 1'b1;
      cyc(10);
      sag_int <= 1'b0;
      hold(SM, 0, 2100);
      chk("short dip", 0, volt_dip);
      $display("test short dip done");
      for (int i = 0; i < 6; i++) begin
         e = dtab[i];
         wr(`MSUP_REG_CTRL, {30'h0, e[6:5]});
         wr(`MSUP_REG_MED, e[4] ? 32'hA : 32'h0);
         wr(`MSUP_REG_LONG, e[3] ? 32'hA : 32'h0);
         if (sense.pos !== 1'b1) pls(0);
         cyc(5);
         if (e[5]) sag_int <= 1'b1;
         else sag_ext <= 1'b1;
         wt(VD, 1, 60, n);
         chk("dip delay", 1, n > 30);
         cyc(2);
         chk("armed", e[1], restart_armed);
         if (e[2]) begin
            cyc(8);
            sag_int <= 1'b0;
            sag_ext <= 1'b0;
         end
         if (e[0]) begin
            wt(CO, 1, 12, n);
            chk("event", 1, restart_event);
         end else if (e[1]) begin
            wt(RA, 0, 60, n);
            chk("no close", 0, close_order);
         end else begin
            hold(CO, 0, 10);
         end
         sag_int <= 1'b0;
         sag_ext <= 1'b0;
         cyc(10);
         chk("dip clear", 0, volt_dip);
         $display("test dip case %0d done", i);
      end
      final_report();
   end
endmodule : testbench
